// ### logic/nio_consts.svh
// Constants of the nibble port group: register offsets, field positions,
// command codes and reset levels.
// Assumes inclusion by bare name from the design files that need it.
`ifndef NIO_CONSTS_SVH
`define NIO_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define NIO_CMD_OFS 4'h0
`define NIO_RES_OFS 4'h4
`define NIO_PIN_OFS 4'h8

// ----------------------------------------
// Command codes
// ----------------------------------------
`define NIO_OP_READ   3'h0
`define NIO_OP_WRITE  3'h1
`define NIO_OP_BR_SET 3'h2
`define NIO_OP_BR_CLR 3'h3
`define NIO_OP_B_SET  3'h4
`define NIO_OP_B_CLR  3'h5
`define NIO_OP_HALT   3'h6

// ----------------------------------------
// Port select codes
// ----------------------------------------
`define NIO_SEL_A 2'h0
`define NIO_SEL_C 2'h1
`define NIO_SEL_D 2'h2
`define NIO_SEL_E 2'h3

// ----------------------------------------
// Result register fields and reset levels
// ----------------------------------------
`define NIO_RES_TAKEN 4
`define NIO_RES_STBY  5
`define NIO_RES_ERR   6
`define NIO_PA_RST    4'hF
`define NIO_GRP_HI    4'hF
`define NIO_GRP_LO    4'h0
`define NIO_PU_NONE   4'h0

`endif

// ### logic/nio_pkg.sv
// Types of the nibble port group.
// Assumes nothing of its surroundings.
package nio_pkg;
	// Run or standby after a halt command.
	typedef enum logic {NIO_RUN, NIO_STANDBY} nio_mode_t;

	// Command word as written to the command register, low twelve bits.
	typedef struct packed {
		logic [3:0] data;
		logic       pad;
		logic [1:0] bsel;
		logic [1:0] psel;
		logic [2:0] op;
	} nio_cmd_t;
endpackage : nio_pkg

// ### logic/nio_port_if.sv
// Carrier between the group logic and one bidirectional port slice.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface nio_port_if;
	logic       wr_all;  // Load the whole latch.
	logic [3:0] wr_data; // Value for a whole load.
	logic       set_bit; // Set one latch bit.
	logic       clr_bit; // Clear one latch bit.
	logic [1:0] bit_sel; // Bit for set or clear.
	logic [3:0] pin_lvl; // Synchronised pin levels.
	logic [3:0] latch;   // Present latch value.

	modport ctrl (output wr_all, wr_data, set_bit, clr_bit, bit_sel,
		input pin_lvl, latch);
	modport port (input wr_all, wr_data, set_bit, clr_bit, bit_sel,
		output pin_lvl, latch);
endinterface : nio_port_if

// ### logic/nio_bidir_port.sv
// One 4-bit bidirectional port: output latch, pin drivers, input synchroniser.
// Assumes command strobes come from logic on the same clock, one at a time.
`timescale 1ns/1ps
`include "nio_consts.svh"
module nio_bidir_port #(
	parameter logic [3:0] RST_LVL = `NIO_PA_RST,  // Latch value after reset.
	parameter logic [3:0] PU_MASK = `NIO_PU_NONE  // Bits built with pull-up.
) (
	input  wire logic       clk_i,    // Core clock.
	input  wire logic       rst_i,    // Synchronous reset, high.
	nio_port_if.port        pif,      // Commands from the group logic.
	input  wire logic [3:0] pin_i,    // Pin levels, asynchronous.
	output logic      [3:0] pin_o,    // Output latch, the pin value.
	output logic      [3:0] pin_oe_o, // Pull-down enable, high drives low.
	output logic      [3:0] pin_pu_o  // Pull-up enable per bit.
);
	logic [3:0] latch_nxt;
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;

	// ----------------------------------------
	// Output latch
	// ----------------------------------------
	// Whole loads win over bit commands; the group never sends both.
	always_comb begin
		latch_nxt = pin_o;
		if (pif.wr_all) begin
			latch_nxt = pif.wr_data;
		end else if (pif.set_bit) begin
			latch_nxt[pif.bit_sel] = 1'b1;
		end else if (pif.clr_bit) begin
			latch_nxt[pif.bit_sel] = 1'b0;
		end
	end

	// A high latch bit releases the pin; only a low bit sinks current.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o    <= RST_LVL;
			pin_oe_o <= ~RST_LVL;
			pin_pu_o <= RST_LVL & PU_MASK;
		end else begin
			pin_o    <= latch_nxt;
			pin_oe_o <= ~latch_nxt;
			pin_pu_o <= latch_nxt & PU_MASK;
		end
	end

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	// Pins are asynchronous, so two stages precede any reader.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end else begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
		end
	end

	assign pif.pin_lvl = sync2_r;
	assign pif.latch   = pin_o;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_rst_lvl;
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> (pin_o == RST_LVL) && (pin_oe_o == ~RST_LVL);
	endproperty
	a_rst_lvl: assert property (p_rst_lvl)
		else $error("Port latch not at its reset level after reset.");

	property p_drive;
		@(posedge clk_i) disable iff (rst_i)
		(pin_oe_o == ~pin_o) && (pin_pu_o == (pin_o & PU_MASK));
	endproperty
	a_drive: assert property (p_drive)
		else $error("Pin drive does not follow latch and pull-up choice.");
endmodule : nio_bidir_port

// ### logic/nio_port_group.sv
// Top of the nibble port group: three bidirectional ports, one input port,
// the standby control and a Wishbone slave that carries port commands.
// Assumes a classic Wishbone master on clk_i and asynchronous pins.
//
// Behaviour
// - A read command returns the four synchronised pin levels of the port.
// - A write command loads all four output latch bits of the port at once.
// - Branch commands report whether one port bit is set or is clear.
// - Bit set and bit clear commands change one output latch bit.
// - Port A bit 3 also serves as the standby release input.
// - A halt command puts the chip into standby.
// - After reset all port A outputs are high with the pull-down off.
// - Port C has all port A functions except the standby control.
// - Ports C and D each take a high or low reset level for all 4 bits.
// - Port D behaves exactly as port C.
// - Each port bit is open drain or has a pull-up, chosen per bit.
// - Four input-only lines may instead carry comparator results.
// - The input port reads as 4 bits and takes branch commands.
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "nio_consts.svh"
module nio_port_group #(
	parameter logic [3:0] PU_A       = `NIO_PU_NONE, // Pull-up bits, port A.
	parameter logic [3:0] PU_C       = `NIO_PU_NONE, // Pull-up bits, port C.
	parameter logic [3:0] PU_D       = `NIO_PU_NONE, // Pull-up bits, port D.
	parameter logic       C_RST_HIGH = 1'b1,         // Port C resets high.
	parameter logic       D_RST_HIGH = 1'b1,         // Port D resets high.
	parameter logic       CMP_MODE   = 1'b0          // Port E reads comparators.
) (
	input  wire logic        clk_i,               // Core clock, 200 MHz.
	input  wire logic        rst_i,               // Synchronous reset, high.
	input  wire logic        wb_cyc_i,            // Bus cycle.
	input  wire logic        wb_stb_i,            // Bus strobe.
	input  wire logic        wb_we_i,             // Bus write.
	input  wire logic [3:0]  wb_adr_i,            // Byte address.
	input  wire logic [3:0]  wb_sel_i,            // Byte lanes.
	input  wire logic [31:0] wb_dat_i,            // Write data.
	output logic      [31:0] wb_dat_o,            // Read data.
	output logic             wb_ack_o,            // Bus acknowledge.
	input  wire logic [3:0]  port_a_i,            // Port A pin levels.
	output logic      [3:0]  port_a_o,            // Port A output value.
	output logic      [3:0]  port_a_oe_o,         // Port A pull-down enable.
	output logic      [3:0]  port_a_pu_o,         // Port A pull-up enable.
	input  wire logic [3:0]  port_c_i,            // Port C pin levels.
	output logic      [3:0]  port_c_o,            // Port C output value.
	output logic      [3:0]  port_c_oe_o,         // Port C pull-down enable.
	output logic      [3:0]  port_c_pu_o,         // Port C pull-up enable.
	input  wire logic [3:0]  port_d_i,            // Port D pin levels.
	output logic      [3:0]  port_d_o,            // Port D output value.
	output logic      [3:0]  port_d_oe_o,         // Port D pull-down enable.
	output logic      [3:0]  port_d_pu_o,         // Port D pull-up enable.
	input  wire logic [3:0]  input_port_e_i,      // Input port pin levels.
	input  wire logic [3:0]  comparator_inputs_i, // Comparator results.
	output logic             standby_o            // Chip standby, high.
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	nio_port_if pif_a ();
	nio_port_if pif_c ();
	nio_port_if pif_d ();

	nio_pkg::nio_cmd_t  cmd;
	nio_pkg::nio_mode_t mode_r;
	logic        hit;
	logic        acc;
	logic        cmd_wr;
	logic        exec;
	logic [2:0]  op;
	logic [1:0]  psel;
	logic [1:0]  bsel;
	logic [3:0]  wdata;
	logic        is_write;
	logic        is_set;
	logic        is_clr;
	logic        is_branch;
	logic        illegal;
	logic        err_clr;
	logic [3:0]  lvl_sel;
	logic        bit_lvl;
	logic        pa3_lvl;
	logic [3:0]  e_src;
	logic [3:0]  e_sync1_r;
	logic [3:0]  e_lvl_r;
	logic [3:0]  res_data_r;
	logic        taken_r;
	logic        err_r;
	logic [11:0] last_cmd_r;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// One wait cycle: ack follows the request by one edge, then drops.
	assign hit = wb_cyc_i & wb_stb_i;
	assign acc = hit & wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= hit & ~wb_ack_o;
		end
	end

	// Read data is captured with ack, so it stands for the whole ack cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (hit && !wb_ack_o) begin
			case (wb_adr_i)
				`NIO_CMD_OFS: begin
					wb_dat_o <= {20'h00000, last_cmd_r};
				end
				`NIO_RES_OFS: begin
					wb_dat_o <= {25'h0000000, err_r, standby_o, taken_r,
						res_data_r};
				end
				`NIO_PIN_OFS: begin
					wb_dat_o <= {4'h0, pif_d.latch, pif_c.latch, pif_a.latch,
						e_lvl_r, pif_d.pin_lvl, pif_c.pin_lvl, pif_a.pin_lvl};
				end
				default: begin
					wb_dat_o <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	// A command takes effect at the edge where the master sees ack. Both
	// low byte lanes must be enabled, so a partial word never half-executes.
	assign cmd    = nio_pkg::nio_cmd_t'(wb_dat_i[11:0]);
	assign op     = cmd.op;
	assign psel   = cmd.psel;
	assign bsel   = cmd.bsel;
	assign wdata  = cmd.data;
	assign cmd_wr = acc & wb_we_i & (wb_adr_i == `NIO_CMD_OFS)
		& (wb_sel_i[1:0] == 2'h3);
	assign exec   = cmd_wr & (mode_r == nio_pkg::NIO_RUN);

	assign is_write  = exec & (op == `NIO_OP_WRITE);
	assign is_set    = exec & (op == `NIO_OP_B_SET);
	assign is_clr    = exec & (op == `NIO_OP_B_CLR);
	assign is_branch = exec & ((op == `NIO_OP_BR_SET) | (op == `NIO_OP_BR_CLR));

	// The input-only port has no latch; output commands to it are errors.
	assign illegal = (is_write | is_set | is_clr) & (psel == `NIO_SEL_E);
	assign err_clr = acc & wb_we_i & (wb_adr_i == `NIO_RES_OFS) & wb_sel_i[0]
		& wb_dat_i[`NIO_RES_ERR];

	// ----------------------------------------
	// Port level selection
	// ----------------------------------------
	always_comb begin
		unique case (psel)
			`NIO_SEL_A: lvl_sel = pif_a.pin_lvl;
			`NIO_SEL_C: lvl_sel = pif_c.pin_lvl;
			`NIO_SEL_D: lvl_sel = pif_d.pin_lvl;
			`NIO_SEL_E: lvl_sel = e_lvl_r;
		endcase
	end

	assign bit_lvl = lvl_sel[bsel];
	assign pa3_lvl = pif_a.pin_lvl[3];

	// ----------------------------------------
	// Input-only port
	// ----------------------------------------
	// The source is fixed at build time, so the mux ahead of the
	// synchroniser never switches and cannot glitch.
	assign e_src = CMP_MODE ? comparator_inputs_i : input_port_e_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			e_sync1_r <= 4'h0;
			e_lvl_r   <= 4'h0;
		end else begin
			e_sync1_r <= e_src;
			e_lvl_r   <= e_sync1_r;
		end
	end

	// ----------------------------------------
	// Port commands
	// ----------------------------------------
	// Each slice gets strobes only when it is the addressed port.
	assign pif_a.wr_all  = is_write & (psel == `NIO_SEL_A);
	assign pif_a.wr_data = wdata;
	assign pif_a.set_bit = is_set & (psel == `NIO_SEL_A);
	assign pif_a.clr_bit = is_clr & (psel == `NIO_SEL_A);
	assign pif_a.bit_sel = bsel;

	assign pif_c.wr_all  = is_write & (psel == `NIO_SEL_C);
	assign pif_c.wr_data = wdata;
	assign pif_c.set_bit = is_set & (psel == `NIO_SEL_C);
	assign pif_c.clr_bit = is_clr & (psel == `NIO_SEL_C);
	assign pif_c.bit_sel = bsel;

	assign pif_d.wr_all  = is_write & (psel == `NIO_SEL_D);
	assign pif_d.wr_data = wdata;
	assign pif_d.set_bit = is_set & (psel == `NIO_SEL_D);
	assign pif_d.clr_bit = is_clr & (psel == `NIO_SEL_D);
	assign pif_d.bit_sel = bsel;

	// ----------------------------------------
	// Read and branch results
	// ----------------------------------------
	// A read leaves the branch flag alone and a branch leaves the data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_data_r <= 4'h0;
		end else if (exec && (op == `NIO_OP_READ)) begin
			res_data_r <= lvl_sel;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			taken_r <= 1'b0;
		end else if (is_branch) begin
			taken_r <= (op == `NIO_OP_BR_SET) ? bit_lvl : ~bit_lvl;
		end
	end

	// The last accepted command word is kept so software can read it back.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_cmd_r <= 12'h000;
		end else if (exec) begin
			last_cmd_r <= wb_dat_i[11:0];
		end
	end

	// A new error in the clearing cycle wins over the clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_r <= 1'b0;
		end else if (illegal) begin
			err_r <= 1'b1;
		end else if (err_clr) begin
			err_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Standby control
	// ----------------------------------------
	// Commands written in standby are acknowledged but ignored. Release
	// needs a low level on port A bit 3; a bouncing pin there during the
	// halt would end standby at once, which the board must prevent.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= nio_pkg::NIO_RUN;
		end else begin
			unique case (mode_r)
				nio_pkg::NIO_RUN: begin
					if (exec && (op == `NIO_OP_HALT)) begin
						mode_r <= nio_pkg::NIO_STANDBY;
					end
				end
				nio_pkg::NIO_STANDBY: begin
					if (!pa3_lvl) begin
						mode_r <= nio_pkg::NIO_RUN;
					end
				end
			endcase
		end
	end

	assign standby_o = (mode_r == nio_pkg::NIO_STANDBY);

	// ----------------------------------------
	// Port slices
	// ----------------------------------------
	nio_bidir_port #(
		.RST_LVL (`NIO_PA_RST),
		.PU_MASK (PU_A)
	) u_port_a (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pif      (pif_a.port),
		.pin_i    (port_a_i),
		.pin_o    (port_a_o),
		.pin_oe_o (port_a_oe_o),
		.pin_pu_o (port_a_pu_o)
	);

	nio_bidir_port #(
		.RST_LVL (C_RST_HIGH ? `NIO_GRP_HI : `NIO_GRP_LO),
		.PU_MASK (PU_C)
	) u_port_c (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pif      (pif_c.port),
		.pin_i    (port_c_i),
		.pin_o    (port_c_o),
		.pin_oe_o (port_c_oe_o),
		.pin_pu_o (port_c_pu_o)
	);

	nio_bidir_port #(
		.RST_LVL (D_RST_HIGH ? `NIO_GRP_HI : `NIO_GRP_LO),
		.PU_MASK (PU_D)
	) u_port_d (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pif      (pif_d.port),
		.pin_i    (port_d_i),
		.pin_o    (port_d_o),
		.pin_oe_o (port_d_oe_o),
		.pin_pu_o (port_d_pu_o)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		(hit && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("Bus ack not a single pulse one cycle after request.");

	property p_read;
		@(posedge clk_i) disable iff (rst_i)
		(exec && (op == `NIO_OP_READ)) |=> (res_data_r == $past(lvl_sel));
	endproperty
	a_read: assert property (p_read)
		else $error("Read result differs from port levels.");

	property p_read_e;
		@(posedge clk_i) disable iff (rst_i)
		(exec && (op == `NIO_OP_READ) && (psel == `NIO_SEL_E))
			|=> (res_data_r == $past(e_lvl_r));
	endproperty
	a_read_e: assert property (p_read_e)
		else $error("Input port read differs from its levels.");

	property p_write_c;
		@(posedge clk_i) disable iff (rst_i)
		(is_write && (psel == `NIO_SEL_C)) |=> (port_c_o == $past(wdata));
	endproperty
	a_write_c: assert property (p_write_c)
		else $error("Port C latch not loaded by write.");

	property p_bset_d;
		@(posedge clk_i) disable iff (rst_i)
		(is_set && (psel == `NIO_SEL_D))
			|=> (port_d_o == ($past(port_d_o) | (4'h1 << $past(bsel))));
	endproperty
	a_bset_d: assert property (p_bset_d)
		else $error("Bit set changed more than the addressed bit.");

	property p_bclr_a;
		@(posedge clk_i) disable iff (rst_i)
		(is_clr && (psel == `NIO_SEL_A))
			|=> (port_a_o == ($past(port_a_o) & ~(4'h1 << $past(bsel))));
	endproperty
	a_bclr_a: assert property (p_bclr_a)
		else $error("Bit clear changed more than the addressed bit.");

	property p_branch;
		@(posedge clk_i) disable iff (rst_i)
		(is_branch && (op == `NIO_OP_BR_CLR)) |=> (taken_r == !$past(bit_lvl));
	endproperty
	a_branch: assert property (p_branch)
		else $error("Branch on clear bit gave the wrong result.");

	property p_halt;
		@(posedge clk_i) disable iff (rst_i)
		(exec && (op == `NIO_OP_HALT)) |=> standby_o;
	endproperty
	a_halt: assert property (p_halt)
		else $error("Halt did not enter standby.");

	property p_release;
		@(posedge clk_i) disable iff (rst_i)
		standby_o |=> (standby_o == $past(pa3_lvl));
	endproperty
	a_release: assert property (p_release)
		else $error("Standby not governed by port A bit 3.");

	property p_refuse;
		@(posedge clk_i) disable iff (rst_i)
		(standby_o && cmd_wr) |=> $stable(port_a_o) && $stable(port_c_o)
			&& $stable(port_d_o);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("Command acted during standby.");

	property p_err;
		@(posedge clk_i) disable iff (rst_i)
		illegal |=> err_r;
	endproperty
	a_err: assert property (p_err)
		else $error("Output command to input port not flagged.");
endmodule : nio_port_group

// ### sim/nio_pin_env.sv
// Far-side model of one open-drain port: board pull-up and switches to ground.
// Assumes pin enables from the port group and a switch mask from the bench.
`timescale 1ns/1ps
// ----------------------------------------
// Pin resolution
// ----------------------------------------
module nio_pin_env (
	input  wire logic [3:0] oe_i,  // Port sinks the pin when high.
	input  wire logic [3:0] pu_i,  // Port pull-up enable.
	input  wire logic [3:0] sw_i,  // Outside switch closes to ground.
	output logic      [3:0] lvl_o  // Resolved wire level.
);
	// A released line rises through the pull-up, so no bit ever floats.
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			lvl_o[b] = (oe_i[b] | sw_i[b]) ? 1'b0 : (pu_i[b] | 1'b1);
		end
	end
endmodule : nio_pin_env

// ### sim/nio_port_group_tb.sv
// Self-checking bench for the nibble port group with pin models.
// Assumes the group answers a bus request one cycle after taking it.
`timescale 1ns/1ps
`include "nio_consts.svh"
module nio_port_group_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic        wb_ack_o, standby_o;
	logic [3:0]  a_o, a_oe, a_pu, c_o, c_oe, c_pu, d_o, d_oe, d_pu;
	logic [3:0]  a_lvl, c_lvl, d_lvl, sw_a = 4'h0, e_pins = 4'h9, cmp_pins = 4'h6;
	int          errors = 0, cmp_count = 0;

	always #2.5 clk_i = ~clk_i;

	nio_port_group #(.PU_A(4'h3), .PU_C(4'hC), .D_RST_HIGH(1'b0)) u_nio_port_group (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.port_a_i(a_lvl), .port_a_o(a_o), .port_a_oe_o(a_oe), .port_a_pu_o(a_pu),
		.port_c_i(c_lvl), .port_c_o(c_o), .port_c_oe_o(c_oe), .port_c_pu_o(c_pu),
		.port_d_i(d_lvl), .port_d_o(d_o), .port_d_oe_o(d_oe), .port_d_pu_o(d_pu),
		.input_port_e_i(e_pins), .comparator_inputs_i(cmp_pins), .standby_o(standby_o));
	nio_pin_env u_pa (.oe_i(a_oe), .pu_i(a_pu), .sw_i(sw_a), .lvl_o(a_lvl));
	nio_pin_env u_pc (.oe_i(c_oe), .pu_i(c_pu), .sw_i(4'h0), .lvl_o(c_lvl));
	nio_pin_env u_pd (.oe_i(d_oe), .pu_i(d_pu), .sw_i(4'h0), .lvl_o(d_lvl));

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	// Values are taken in the active region after an edge, so they are the settled
	// results of the previous edge and never race the design's own updates.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Single classic cycle; only the watchdog ends a wait, so a slow ack is still
	// seen and then judged against the one-wait-cycle answer.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		chk(n, 32'h2, "ack latency");
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic cmd(input logic [2:0] o, input logic [1:0] p, input logic [1:0] b,
		input logic [3:0] d);
		nio_pkg::nio_cmd_t c;
		c = '{data: d, pad: 1'b0, bsel: b, psel: p, op: o};
		wb(1'b1, `NIO_CMD_OFS, {20'h0, c});
	endtask : cmd

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(a_o, 4'hF, "a reset");
		chk(a_oe, 4'h0, "a sink off");
		chk(a_pu, 4'h3, "a pull-up");
		chk(c_o, 4'hF, "c reset high");
		chk(d_o, 4'h0, "d reset low");
		chk(d_oe, 4'hF, "d sinks");
		chk({c_pu, d_pu}, 8'hC0, "c d pull-up");
		chk(standby_o, 1'b0, "run");
		wb(1'b0, 4'hC, 32'h0);
		chk(q, 32'h0, "unmapped");
		$display("test reset done");
	endtask : t_reset

	task automatic t_write_read();
		cmd(`NIO_OP_WRITE, `NIO_SEL_C, 2'h0, 4'h5);
		chk(c_o, 4'h5, "c write");
		chk(c_oe, 4'hA, "c sinks");
		chk(c_pu, 4'h4, "c pull-up");
		cmd(`NIO_OP_WRITE, `NIO_SEL_D, 2'h0, 4'hA);
		chk(d_o, 4'hA, "d write");
		repeat (3) @(posedge clk_i);
		cmd(`NIO_OP_READ, `NIO_SEL_C, 2'h0, 4'h0);
		wb(1'b0, `NIO_RES_OFS, 32'h0);
		chk(q[3:0], 4'h5, "c read");
		$display("test write_read done");
	endtask : t_write_read

	task automatic t_bits();
		cmd(`NIO_OP_B_CLR, `NIO_SEL_A, 2'h0, 4'h0);
		chk(a_o, 4'hE, "a clear bit");
		cmd(`NIO_OP_B_SET, `NIO_SEL_D, 2'h2, 4'h0);
		chk(d_o, 4'hE, "d set bit");
		cmd(`NIO_OP_B_SET, `NIO_SEL_C, 2'h1, 4'h0);
		chk(c_o, 4'h7, "c set bit");
		repeat (2) @(posedge clk_i);
		wb(1'b0, `NIO_PIN_OFS, 32'h0);
		chk(q, 32'h0E7E_9E7E, "pin levels and latches");
		wb(1'b0, `NIO_CMD_OFS, 32'h0);
		chk(q, 32'h0000_002C, "last command");
		$display("test bits done");
	endtask : t_bits

	// Both branch kinds on every bit of port C (levels 7) and input port (levels 9).
	task automatic t_branch();
		logic [3:0] v;
		sw_a <= 4'h2;
		repeat (4) @(posedge clk_i);
		cmd(`NIO_OP_READ, `NIO_SEL_A, 2'h0, 4'h0);
		wb(1'b0, `NIO_RES_OFS, 32'h0);
		chk(q[3:0], 4'hC, "a read");
		for (int p = 1; p < 4; p += 2) begin
			v = (p == 1) ? 4'h7 : 4'h9;
			for (int k = 0; k < 8; k++) begin
				cmd(`NIO_OP_BR_SET + 3'(k / 4), 2'(p), 2'(k % 4), 4'h0);
				wb(1'b0, `NIO_RES_OFS, 32'h0);
				chk(q[`NIO_RES_TAKEN], v[k % 4] ^ (k >= 4), "taken");
			end
		end
		cmd(`NIO_OP_READ, `NIO_SEL_E, 2'h0, 4'h0);
		wb(1'b0, `NIO_RES_OFS, 32'h0);
		chk(q[3:0], 4'h9, "e read");
		$display("test branch done");
	endtask : t_branch

	task automatic t_error();
		cmd(`NIO_OP_WRITE, `NIO_SEL_E, 2'h0, 4'hF);
		wb(1'b0, `NIO_RES_OFS, 32'h0);
		chk(q[`NIO_RES_ERR], 1'b1, "error set");
		wb(1'b1, `NIO_RES_OFS, 32'h40);
		wb(1'b0, `NIO_RES_OFS, 32'h0);
		chk(q[`NIO_RES_ERR], 1'b0, "error clear");
		$display("test error done");
	endtask : t_error

	// The switch on port A bit 3 stays still until standby is entered.
	task automatic t_halt();
		cmd(`NIO_OP_HALT, `NIO_SEL_A, 2'h0, 4'h0);
		chk(standby_o, 1'b1, "standby");
		cmd(`NIO_OP_WRITE, `NIO_SEL_C, 2'h0, 4'h0);
		chk(c_o, 4'h7, "ignored in standby");
		sw_a <= 4'hA;
		repeat (5) @(posedge clk_i);
		chk(standby_o, 1'b0, "wake");
		$display("test halt done");
	endtask : t_halt

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_write_read();
		t_bits();
		t_branch();
		t_error();
		t_halt();
		complete_run();
	end

	// The tests take some 190 cycles; four thousand leaves ample margin.
	initial begin
		#20000;
		errors++;
		complete_run();
	end
endmodule : nio_port_group_tb
